// ---- dctm_map.vh ----
`ifndef DCTM_MAP_VH
`define DCTM_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define DCTM_ADDR_CTRL      8'h00
`define DCTM_ADDR_MODE      8'h04
`define DCTM_ADDR_CLK       8'h08
`define DCTM_ADDR_T0_LOW    8'h0C
`define DCTM_ADDR_T0_HIGH   8'h10
`define DCTM_ADDR_T1_LOW    8'h14
`define DCTM_ADDR_T1_HIGH   8'h18
`define DCTM_ADDR_IRQ_STAT  8'h1C
`define DCTM_ADDR_IRQ_MASK  8'h20
`define DCTM_ADDR_EXTCFG    8'h24
// ----------------------------------------
// control register fields
// ----------------------------------------
`define DCTM_CTRL_T0_RUN    0
`define DCTM_CTRL_T1_RUN    1
`define DCTM_CTRL_T0_OVF    2
`define DCTM_CTRL_T1_OVF    3
`define DCTM_CTRL_T0_ACK    4
`define DCTM_CTRL_T1_ACK    5
// ----------------------------------------
// mode register fields (per timer nibble)
// ----------------------------------------
`define DCTM_MODE_T1_BASE   4
`define DCTM_MODE_LSB       0
`define DCTM_MODE_CSEL      2
`define DCTM_MODE_GATE      3
`define DCTM_MODE_13BIT     2'h0
`define DCTM_MODE_16BIT     2'h1
`define DCTM_MODE_RELOAD    2'h2
// ----------------------------------------
// clock register fields
// ----------------------------------------
`define DCTM_CLK_SCALE_LSB  0
`define DCTM_CLK_T0_SYS     2
`define DCTM_CLK_T1_SYS     3
// ----------------------------------------
// prescaler divide counts
// ----------------------------------------
`define DCTM_DIV_SCALE0     12'h00B
`define DCTM_DIV_SCALE1     12'h003
`define DCTM_DIV_SCALE2     12'h02F
`define DCTM_DIV_SCALE3     12'h007
// ----------------------------------------
// reset values
// ----------------------------------------
`define DCTM_RST_BYTE       8'h00
`define DCTM_RST_COUNT      16'h0000
`endif

// ---- dctm_edge_sync.v ----
`timescale 1ns/1ps
`include "dctm_map.vh"
// ----------------------------------------
// two stage synchroniser with falling edge pulse
// ----------------------------------------
module dctm_edge_sync (
    input  wire clk_i,
    input  wire resetn_i,
    input  wire pin_i,
    output wire level_o,
    output wire fall_o
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // first stage only feeds the second
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // one cycle pulse on high to low
    assign level_o = sync_q;
    assign fall_o  = prev_q & ~sync_q;
endmodule

// ---- dctm_prescaler.v ----
`timescale 1ns/1ps
`include "dctm_map.vh"
// ----------------------------------------
// shared prescaled tick generator
// ----------------------------------------
module dctm_prescaler (
    input  wire       clk_i,
    input  wire       resetn_i,
    input  wire [1:0] scale_i,
    output reg        tick_o
);
    reg  [11:0] cnt_q;
    reg  [11:0] limit;

    // divide count per clock scale setting
    always @* begin
        case (scale_i)
            2'h0:    limit = `DCTM_DIV_SCALE0;
            2'h1:    limit = `DCTM_DIV_SCALE1;
            2'h2:    limit = `DCTM_DIV_SCALE2;
            default: limit = `DCTM_DIV_SCALE3;
        endcase
    end

    // free running divider, one cycle tick at terminal count
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q  <= 12'h000;
            tick_o <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q  <= 12'h000;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 12'h001;
            tick_o <= 1'b0;
        end
    end
endmodule

// ---- dctm_timers.v ----
`timescale 1ns/1ps
`include "dctm_map.vh"
// ----------------------------------------
// Overview of operation
// - each timer count: sixteen bits, two bytes
// - 13-bit mode: high byte bits 12..5
// - 13-bit rollover sets flag, maybe interrupt
// - counter select counts event pin falls
// - else system clock or prescaled clock
// - advance only when run and gate allow
// - run bit never clears the count
// - 16-bit mode uses all sixteen bits
// - reload mode: low counts, high reloads
// - timer one mirrors timer zero, gate one
// - each timer configured independently, except the shared prescaler scale
// - mode codes 00, 01, 10 select modes
// - flag stays until cleared or acknowledged
// ----------------------------------------
module dctm_timers (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        event_pin_zero_i,
    input  wire        event_pin_one_i,
    input  wire        gate_input_zero_i,
    input  wire        gate_input_one_i,
    output reg         t0_irq_o,
    output reg         t1_irq_o,
    output reg         irq_o
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0]  timer_control_reg_q;
    reg  [7:0]  timer_mode_reg_q;
    reg  [7:0]  timer_clock_reg_q;
    reg  [7:0]  ext_irq_config_reg_q;
    reg  [1:0]  irq_stat_q;
    reg  [1:0]  irq_mask_q;
    reg  [15:0] cnt_q [0:1];
    reg  [1:0]  ovf_q;
    reg  [31:0] aw_addr_q;
    reg         aw_have_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         w_have_q;

    wire [1:0]  ev_fall;
    wire [1:0]  gate_lvl;
    wire        pre_tick;
    wire [1:0]  tick;
    wire [1:0]  ovf_evt;
    wire [15:0] cnt_d [0:1];
    wire        do_write;
    wire        do_read;
    wire [7:0]  wa;
    wire [7:0]  wbyte;
    wire [7:0]  ra;

    assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign do_read  = s_axi_arvalid & s_axi_arready;
    assign wa       = aw_addr_q[7:0];
    assign wbyte    = w_data_q[7:0];
    assign ra       = s_axi_araddr[7:0];

    // ----------------------------------------
    // input conditioning
    // ----------------------------------------
    dctm_edge_sync u_ev0 (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(event_pin_zero_i),
                          .level_o(), .fall_o(ev_fall[0]));
    dctm_edge_sync u_ev1 (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(event_pin_one_i),
                          .level_o(), .fall_o(ev_fall[1]));
    dctm_edge_sync u_g0 (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(gate_input_zero_i),
                         .level_o(gate_lvl[0]), .fall_o());
    dctm_edge_sync u_g1 (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(gate_input_one_i),
                         .level_o(gate_lvl[1]), .fall_o());

    dctm_prescaler u_pre (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .scale_i  (timer_clock_reg_q[`DCTM_CLK_SCALE_LSB+1:`DCTM_CLK_SCALE_LSB]),
        .tick_o   (pre_tick)
    );

    // ----------------------------------------
    // per timer counting logic
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_tmr
            wire [3:0]  mcfg   = timer_mode_reg_q[g*4+3:g*4];
            wire [1:0]  mode   = mcfg[`DCTM_MODE_LSB+1:`DCTM_MODE_LSB];
            wire        run    = timer_control_reg_q[`DCTM_CTRL_T0_RUN+g];
            wire        pol    = ext_irq_config_reg_q[g];
            wire        gok    = ~mcfg[`DCTM_MODE_GATE] | (gate_lvl[g] == pol);
            wire        sysck  = timer_clock_reg_q[`DCTM_CLK_T0_SYS+g];
            wire        src    = mcfg[`DCTM_MODE_CSEL] ? ev_fall[g] :
                                 (sysck ? 1'b1 : pre_tick);
            wire [15:0] c      = cnt_q[g];
            wire [12:0] c13    = {c[15:8], c[4:0]} + 13'h0001;
            wire [16:0] c16    = {1'b0, c} + 17'h00001;
            wire [8:0]  c8     = {1'b0, c[7:0]} + 9'h001;
            reg  [15:0] nxt;
            reg         ov;
            assign tick[g] = run & gok & src;
            // next count and overflow per mode
            always @* begin
                nxt = c;
                ov  = 1'b0;
                case (mode)
                    `DCTM_MODE_13BIT: begin
                        nxt = {c13[12:5], c[7:5], c13[4:0]};
                        ov  = ({c[15:8], c[4:0]} == 13'h1FFF);
                    end
                    `DCTM_MODE_16BIT: begin
                        nxt = c16[15:0];
                        ov  = c16[16];
                    end
                    `DCTM_MODE_RELOAD: begin
                        nxt = c8[8] ? {c[15:8], c[15:8]} : {c[15:8], c8[7:0]};
                        ov  = c8[8];
                    end
                    default: begin
                        nxt = c;
                        ov  = 1'b0;
                    end
                endcase
            end
            assign cnt_d[g]   = tick[g] ? nxt : c;
            assign ovf_evt[g] = tick[g] & ov;
        end
    endgenerate

    // ----------------------------------------
    // count registers and software byte writes
    // ----------------------------------------
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q[0] <= `DCTM_RST_COUNT;
            cnt_q[1] <= `DCTM_RST_COUNT;
        end else begin
            cnt_q[0] <= cnt_d[0];
            cnt_q[1] <= cnt_d[1];
            if (do_write && w_strb_q[0]) begin
                case (wa)
                    `DCTM_ADDR_T0_LOW:  cnt_q[0][7:0]  <= wbyte;
                    `DCTM_ADDR_T0_HIGH: cnt_q[0][15:8] <= wbyte;
                    `DCTM_ADDR_T1_LOW:  cnt_q[1][7:0]  <= wbyte;
                    `DCTM_ADDR_T1_HIGH: cnt_q[1][15:8] <= wbyte;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // configuration, flags and interrupt status
    // ----------------------------------------
    always @(posedge clk_i or negedge resetn_i) begin : cfg_p
        reg [1:0] clr;
        reg [1:0] rdclr;
        clr   = 2'h0;
        rdclr = 2'h0;
        if (!resetn_i) begin
            timer_control_reg_q  <= `DCTM_RST_BYTE;
            timer_mode_reg_q     <= `DCTM_RST_BYTE;
            timer_clock_reg_q    <= `DCTM_RST_BYTE;
            ext_irq_config_reg_q <= `DCTM_RST_BYTE;
            irq_mask_q           <= 2'h0;
            irq_stat_q           <= 2'h0;
            ovf_q                <= 2'h0;
        end else begin
            if (do_write && w_strb_q[0]) begin
                case (wa)
                    `DCTM_ADDR_CTRL: begin
                        timer_control_reg_q <= {6'h00, wbyte[1:0]};
                        clr = ~wbyte[3:2] | wbyte[5:4];
                    end
                    `DCTM_ADDR_MODE:     timer_mode_reg_q     <= wbyte;
                    `DCTM_ADDR_CLK:      timer_clock_reg_q    <= {4'h0, wbyte[3:0]};
                    `DCTM_ADDR_EXTCFG:   ext_irq_config_reg_q <= {6'h00, wbyte[1:0]};
                    `DCTM_ADDR_IRQ_MASK: irq_mask_q           <= wbyte[1:0];
                    default: begin
                    end
                endcase
            end
            if (do_read && ra == `DCTM_ADDR_IRQ_STAT) begin
                rdclr = 2'h3;
            end
            // set wins over clear
            ovf_q      <= ovf_evt | (ovf_q & ~clr);
            irq_stat_q <= ovf_evt | (irq_stat_q & ~rdclr);
        end
    end

    // ----------------------------------------
    // interrupt outputs
    // ----------------------------------------
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            t0_irq_o <= 1'b0;
            t1_irq_o <= 1'b0;
            irq_o    <= 1'b0;
        end else begin
            t0_irq_o <= ovf_q[0] & irq_mask_q[0];
            t1_irq_o <= ovf_q[1] & irq_mask_q[1];
            irq_o    <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 32'h00000000;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wa > `DCTM_ADDR_EXTCFG || wa[1:0] != 2'h0 || wa == `DCTM_ADDR_IRQ_STAT ||
                                 aw_addr_q[31:8] != 24'h000000) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'h0;
                if (s_axi_araddr[31:8] != 24'h000000) begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end else begin
                    case (ra)
                        `DCTM_ADDR_CTRL:     s_axi_rdata <= {28'h0, ovf_q, timer_control_reg_q[1:0]};
                        `DCTM_ADDR_MODE:     s_axi_rdata <= {24'h0, timer_mode_reg_q};
                        `DCTM_ADDR_CLK:      s_axi_rdata <= {24'h0, timer_clock_reg_q};
                        `DCTM_ADDR_T0_LOW:   s_axi_rdata <= {24'h0, cnt_q[0][7:0]};
                        `DCTM_ADDR_T0_HIGH:  s_axi_rdata <= {24'h0, cnt_q[0][15:8]};
                        `DCTM_ADDR_T1_LOW:   s_axi_rdata <= {24'h0, cnt_q[1][7:0]};
                        `DCTM_ADDR_T1_HIGH:  s_axi_rdata <= {24'h0, cnt_q[1][15:8]};
                        `DCTM_ADDR_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_q};
                        `DCTM_ADDR_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_q};
                        `DCTM_ADDR_EXTCFG:   s_axi_rdata <= {24'h0, ext_irq_config_reg_q};
                        default: begin
                            s_axi_rdata <= 32'h00000000;
                            s_axi_rresp <= 2'h2;
                        end
                    endcase
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ---- dctm_timers_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// bus and interrupt checks on the top ports
// ----------------------------------------
module dctm_timers_props (
    input wire        clk_i,
    input wire        resetn_i,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        t0_irq_o,
    input wire        t1_irq_o,
    input wire        irq_o
);
    reg [3:0] idle_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // cycles since the bus last answered, saturating
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            idle_q <= 4'h0;
        else if (s_axi_bvalid || s_axi_rvalid)
            idle_q <= 4'h0;
        else if (idle_q != 4'hF)
            idle_q <= idle_q + 4'h1;
    end
    // answers and their hold
    a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered on the next cycle");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before taken");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before taken");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken while data pending");
    a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read returned nonzero data");
    // sticky flags only fall after a bus access
    a_t0_flag_sticky: assert property ($fell(t0_irq_o) |-> s_axi_bvalid || idle_q < 4'h4)
        else $error("timer zero request fell without a write");
    a_t1_flag_sticky: assert property ($fell(t1_irq_o) |-> s_axi_bvalid || idle_q < 4'h4)
        else $error("timer one request fell without a write");
    a_status_sticky: assert property ($fell(irq_o) |-> s_axi_rvalid || s_axi_bvalid || idle_q < 4'h4)
        else $error("interrupt fell without a bus access");
    c_t0_irq: cover property (t0_irq_o && irq_o);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_flag_only: cover property (t1_irq_o && !irq_o);
endmodule

bind dctm_timers dctm_timers_props dctm_timers_props_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .t0_irq_o(t0_irq_o), .t1_irq_o(t1_irq_o), .irq_o(irq_o));

// ---- dctm_pins_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// external event and gate source
// ----------------------------------------
module dctm_pins_model (
    input  wire clk_i,
    output reg  event_zero_o,
    output reg  event_one_o,
    output reg  gate_zero_o,
    output reg  gate_one_o
);
    // events idle high so only pulses make falls
    initial begin
        event_zero_o = 1'b1;
        event_one_o = 1'b1;
        gate_zero_o = 1'b0;
        gate_one_o = 1'b0;
    end
    // n falls, low held three clocks, high three
    task pulse(input integer t, input integer n);
        begin
            repeat (n) begin
                @(posedge clk_i);
                if (t == 0) event_zero_o <= 1'b0;
                else event_one_o <= 1'b0;
                repeat (3) @(posedge clk_i);
                if (t == 0) event_zero_o <= 1'b1;
                else event_one_o <= 1'b1;
                repeat (2) @(posedge clk_i);
            end
            repeat (4) @(posedge clk_i);
        end
    endtask
    // set a gate level
    task gate(input integer t, input integer v);
        begin
            @(posedge clk_i);
            if (t == 0) gate_zero_o <= v[0];
            else gate_one_o <= v[0];
        end
    endtask
endmodule

// ---- dual_counter_timer_modes_bench.sv ----
`timescale 1ns/1ps
`include "dctm_map.vh"
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module dual_counter_timer_modes_bench;
    reg         clk_i = 1'b0;
    reg         resetn_i = 1'b0;
    reg  [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0;
    reg         aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    wire [31:0] r_d;
    wire [1:0]  b_s, r_s;
    wire        aw_r, w_r, b_v, ar_r, r_v, i0, i1, irq, ev0, ev1, g0, g1;
    integer     errors = 0, tests_run = 0, cyc = 0;
    integer     cnt [0:1], flg [0:1], gl [0:1];
    integer     st, rv, rs, t_a, t_b, v_a, i;

    dctm_timers dctm_timers_i (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_s), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .event_pin_zero_i(ev0), .event_pin_one_i(ev1), .gate_input_zero_i(g0),
        .gate_input_one_i(g1), .t0_irq_o(i0), .t1_irq_o(i1), .irq_o(irq));
    dctm_pins_model dctm_pins_model_i (.clk_i(clk_i), .event_zero_o(ev0), .event_one_o(ev1),
        .gate_zero_o(g0), .gate_one_o(g1));

    // clock and cycle limit
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            conclude;
        end
    end
    // ----------------------------------------
    // bus tasks and comparison
    // ----------------------------------------
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        reg aw;
        reg w;
        begin
            aw = 1'b1;
            w = 1'b1;
            aw_a <= a;
            w_d <= d;
            aw_v <= 1'b1;
            w_v <= 1'b1;
            b_r <= a[2];
            while (aw || w) begin
                @(posedge clk_i);
                if (aw && aw_r) begin
                    aw = 1'b0;
                    aw_v <= 1'b0;
                end
                if (w && w_r) begin
                    w = 1'b0;
                    w_v <= 1'b0;
                end
            end
            while (!(b_v && b_r)) begin
                @(posedge clk_i);
                if (b_v && !b_r)
                    b_r <= 1'b1;
            end
            rs = b_s;
        end
    endtask
    task rd(input [31:0] a);
        reg ar;
        begin
            ar = 1'b1;
            ar_a <= a;
            ar_v <= 1'b1;
            r_r <= a[2];
            while (ar || !(r_v && r_r)) begin
                @(posedge clk_i);
                if (ar && ar_r) begin
                    ar = 1'b0;
                    ar_v <= 1'b0;
                    t_b = cyc;
                end else if (r_v && !r_r) begin
                    r_r <= 1'b1;
                end
            end
            rv = r_d;
            rs = r_s;
        end
    endtask
    // ----------------------------------------
    // counter model and event scenario
    // ----------------------------------------
    function void adv(input integer t, input integer m);
        integer lo, hi, c;
        lo = cnt[t] & 255;
        hi = cnt[t] >> 8;
        if (m == 0) begin
            c = ((hi << 5) | (lo & 31)) + 1;
            if (c == 8192) begin
                c = 0;
                flg[t] = 1;
            end
            cnt[t] = ((c >> 5) << 8) | (lo & 224) | (c & 31);
        end else if (m == 1) begin
            c = cnt[t] + 1;
            if (c == 65536) begin
                c = 0;
                flg[t] = 1;
            end
            cnt[t] = c;
        end else if (m == 2) begin
            lo = lo + 1;
            if (lo == 256) begin
                lo = hi;
                flg[t] = 1;
            end
            cnt[t] = (hi << 8) | lo;
        end
    endfunction
    task evt(input integer t, input integer m, input integer s, input integer n, input integer ge,
             input integer run);
        integer k;
        begin
            wr(`DCTM_ADDR_MODE, (m + 4 + 8 * ge) << (4 * t));
            wr(`DCTM_ADDR_T0_LOW + 8 * t, s & 255);
            wr(`DCTM_ADDR_T0_HIGH + 8 * t, s >> 8);
            wr(`DCTM_ADDR_CTRL, 12 + (run << t));
            cnt[t] = s;
            dctm_pins_model_i.pulse(t, n);
            if (run && (!ge || gl[t]))
                for (k = 0; k < n; k = k + 1)
                    adv(t, m);
            wr(`DCTM_ADDR_CTRL, 12);
            rd(`DCTM_ADDR_T0_LOW + 8 * t);
            chk(rv, cnt[t] & 255);
            rd(`DCTM_ADDR_T0_HIGH + 8 * t);
            chk(rv, cnt[t] >> 8);
            rd(`DCTM_ADDR_CTRL);
            chk(rv, 4 * flg[0] + 8 * flg[1]);
            $display("test done: timer %0d mode %0d", t, m);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d, mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (i = 0; i < 2; i = i + 1) begin
            cnt[i] = 0;
            flg[i] = 0;
            gl[i] = 0;
        end
        i = $urandom(32'hE1E4);
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        for (i = 0; i < 40; i = i + 4) begin
            rd(i);
            chk(rv, 0);
        end
        rd(40);
        chk(rs, 2);
        wr(`DCTM_ADDR_IRQ_STAT, 1);
        chk(rs, 2);
        wr(`DCTM_ADDR_EXTCFG, 3);
        wr(`DCTM_ADDR_IRQ_MASK, 3);
        $display("test done: register defaults");
        // roll over, status clear on read, acknowledge
        evt(0, 0, 16'hFF1E, 2 + $urandom % 4, 0, 1);
        chk(i0, 1);
        chk(irq, 1);
        rd(`DCTM_ADDR_IRQ_STAT);
        chk(rv, 1);
        rd(`DCTM_ADDR_IRQ_STAT);
        chk(rv, 0);
        repeat (2) @(posedge clk_i);
        chk(irq, 0);
        wr(`DCTM_ADDR_CTRL, 16);
        flg[0] = 0;
        repeat (2) @(posedge clk_i);
        chk(i0, 0);
        // masked overflow on timer one
        wr(`DCTM_ADDR_IRQ_MASK, 0);
        evt(1, 1, 16'hFFFE, 2 + $urandom % 3, 0, 1);
        chk(irq, 0);
        wr(`DCTM_ADDR_IRQ_MASK, 3);
        repeat (2) @(posedge clk_i);
        chk(i1, 1);
        rd(`DCTM_ADDR_IRQ_STAT);
        chk(rv, 2);
        wr(`DCTM_ADDR_CTRL, 0);
        flg[1] = 0;
        // reload, idle mode, gating and run control
        evt(0, 2, 16'h80FE, 4, 0, 1);
        evt(1, 2, 16'h00FD | ($urandom % 256) << 8, 5, 0, 1);
        evt(1, 3, 16'h1234, 2, 0, 1);
        evt(1, 1, $urandom % 4096, 3, 1, 1);
        dctm_pins_model_i.gate(1, 1);
        gl[1] = 1;
        evt(1, 1, $urandom % 4096, 3, 1, 1);
        evt(0, 1, $urandom % 4096, 2, 1, 1);
        evt(0, 1, $urandom % 4096, 3, 0, 0);
        // system clock, then prescaled by four
        wr(`DCTM_ADDR_MODE, 1);
        wr(`DCTM_ADDR_CLK, 4);
        wr(`DCTM_ADDR_CTRL, 13);
        rd(`DCTM_ADDR_T0_LOW);
        v_a = rv;
        t_a = t_b;
        repeat (20) @(posedge clk_i);
        rd(`DCTM_ADDR_T0_LOW);
        chk((rv - v_a) & 255, (t_b - t_a) & 255);
        wr(`DCTM_ADDR_CLK, 1);
        rd(`DCTM_ADDR_T0_LOW);
        v_a = rv;
        t_a = t_b;
        repeat (40) @(posedge clk_i);
        rd(`DCTM_ADDR_T0_LOW);
        st = ((rv - v_a) & 255) - (t_b - t_a) / 4;
        chk(st >= 0 && st <= 1, 1);
        wr(`DCTM_ADDR_CTRL, 12);
        $display("test done: clock sources");
        conclude;
    end
endmodule
